// ==== include/hub_cfg_pkg.sv ====
/*
 hub_cfg_pkg: image layout, default values, register map and shared
 types of the hub configuration loader.
 Assumes only a SystemVerilog compiler; no other package is needed.
*/
package hub_cfg_pkg;
   // image format tags in byte 0
   localparam logic [7:0] TAG_ID_ONLY = 8'hD0;
   localparam logic [7:0] TAG_SHORT = 8'hD2;
   localparam logic [7:0] TAG_EXT = 8'hD4;
   localparam logic [7:0] TAG_BLANK = 8'hFF;

   // image byte offsets
   localparam int IMG_DEPTH = 24;
   localparam logic [4:0] OFF_VID_LO = 5'h01;
   localparam logic [4:0] OFF_VID_HI = 5'h02;
   localparam logic [4:0] OFF_PID_LO = 5'h03;
   localparam logic [4:0] OFF_PID_HI = 5'h04;
   localparam logic [4:0] OFF_DID = 5'h06;
   localparam logic [4:0] OFF_OC = 5'h07;
   localparam logic [4:0] OFF_S_PORTS = 5'h08;
   localparam logic [4:0] OFF_S_BUDGET = 5'h09;
   localparam logic [4:0] OFF_S_CTRL = 5'h0A;
   localparam logic [4:0] OFF_S_SETTLE = 5'h0B;
   localparam logic [4:0] OFF_S_FLAGS = 5'h0C;
   localparam logic [4:0] OFF_X_BUDGET_FS = 5'h08;
   localparam logic [4:0] OFF_X_BUDGET_HS = 5'h09;
   localparam logic [4:0] OFF_X_CTRL = 5'h0C;
   localparam logic [4:0] OFF_X_SETTLE = 5'h10;
   localparam logic [4:0] OFF_X_FLAGS = 5'h11;
   localparam logic [4:0] OFF_X_POL = 5'h12;
   localparam logic [4:0] OFF_X_WP = 5'h13;
   localparam logic [4:0] OFF_X_LANG = 5'h14;
   localparam logic [4:0] OFF_X_STR = 5'h15;
   localparam logic [4:0] OFF_X_USE = 5'h16;
   localparam logic [4:0] OFF_X_DET = 5'h17;

   // flag byte bit positions
   localparam int FLG_ACCEPT0 = 7;
   localparam int FLG_COMPOUND = 6;
   localparam int FLG_FS_ONLY = 5;
   localparam int FLG_NO_IND = 4;
   localparam int FLG_GANG = 2;
   // polarity byte bit positions
   localparam int POL_AMBER = 7;
   localparam int POL_GREEN = 6;
   localparam int POL_SELF = 5;
   localparam int POL_PULSE = 4;
   localparam int POL_PWR = 3;
   localparam int POL_OC = 2;
   localparam int POL_OC_OFF = 1;
   localparam int POL_OC_PP = 0;

   // values in force when the image gives none, then the fixed key, limit and descriptor type values
   localparam logic [7:0] DEF_OC = 8'h88;
   localparam logic [7:0] DEF_PORTS = 8'hFF;
   localparam logic [7:0] DEF_BUDGET_FS = 8'h28;
   localparam logic [7:0] DEF_BUDGET_HS = 8'h57;
   localparam logic [7:0] DEF_CTRL_FS = 8'h50;
   localparam logic [7:0] DEF_CTRL_HS = 8'hAE;
   localparam logic [7:0] DEF_SETTLE = 8'h32;
   localparam logic [7:0] DEF_FLAGS = 8'h80;
   localparam logic [7:0] DEF_POL = 8'h00;
   localparam logic [7:0] WP_KEY = 8'h42;
   localparam logic [7:0] LANG_MAX = 8'h1F;
   localparam logic [7:0] DESC_TYPE_HUB = 8'h29;
   localparam logic [7:0] DESC_TYPE_ZERO = 8'h00;

   // register byte addresses
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_DESC_REQ = 8'h04;
   localparam logic [7:0] REG_OC = 8'h08;
   localparam logic [7:0] REG_PORTS = 8'h0C;
   localparam logic [7:0] REG_POWER = 8'h10;
   localparam logic [7:0] REG_HUBCHAR = 8'h14;
   localparam logic [7:0] REG_POLARITY = 8'h18;
   localparam logic [7:0] REG_STRINGS = 8'h1C;
   localparam logic [7:0] REG_IDS = 8'h20;
   localparam logic [7:0] REG_DID = 8'h24;

   typedef enum logic [2:0] {
      S_TAG = 3'b001,
      S_BODY = 3'b010,
      S_DONE = 3'b100
   } load_state_t;

   typedef enum logic [3:0] {
      FMT_NONE = 4'b0001,
      FMT_ID = 4'b0010,
      FMT_SHORT = 4'b0100,
      FMT_EXT = 4'b1000
   } img_fmt_t;

   typedef struct packed {
      logic [7:0] oc;
      logic [3:0] usable;
      logic [3:0] detach;
      logic [2:0] count;
      logic [3:0] phys_rem;
      logic [7:0] rem_field;
      logic [7:0] budget;
      logic [7:0] ctrl;
      logic [7:0] settle;
      logic [7:0] flags;
      logic [7:0] pol;
      logic [7:0] hubchar;
      logic [7:0] lang;
      logic [7:0] strmap;
      logic str_en;
      logic wp;
      logic [15:0] vid;
      logic [15:0] pid;
      logic [7:0] did;
   } cfg_t;
endpackage

// ==== rtl/hub_eeprom_config_loader.sv ====
/*
 hub_eeprom_config_loader: reads the configuration image from the
 serial EEPROM byte reader after reset, decodes it into hub settings
 and descriptor fields, and exposes them over an AHB-Lite slave.
 Assumes a byte reader on hclk (req held until a one-cycle ack with
 data) and hs_link from logic on hclk; self_power_pin is a board pin.
*/
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module hub_eeprom_config_loader
   import hub_cfg_pkg::*;
#(
   parameter logic [15:0] DEF_VID = 16'h0000, // arbitrary value
   parameter logic [15:0] DEF_PID = 16'h0000, // arbitrary value
   parameter logic [7:0] DEF_DID = 8'h00 // arbitrary value
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [7:0] ee_data,
   input wire logic hs_link,
   input wire logic self_power_pin,
   output logic config_done,
   output logic vendor_class_mode,
   output logic hs_enable,
   output logic [3:0] active_port_oc_filter,
   output logic [3:0] idle_port_oc_filter,
   output logic [3:0] usable_port_mask,
   output logic [3:0] detachable_port_mask,
   output logic [2:0] port_count,
   output logic [3:0] phys_removable,
   output logic [7:0] device_removable_field,
   output logic [7:0] upstream_current_budget,
   output logic [7:0] controller_current_draw,
   output logic [7:0] port_power_settle_time,
   output logic [7:0] hub_characteristics,
   output logic accept_zero_desc_type,
   output logic compound_flag,
   output logic fs_only_flag,
   output logic indicator_disable,
   output logic shared_power_switching,
   output logic amber_led_polarity,
   output logic green_led_polarity,
   output logic led_pulse_enable,
   output logic power_switch_polarity,
   output logic oc_input_polarity,
   output logic oc_detect_disable,
   output logic oc_per_port_report,
   output logic [7:0] language_count,
   output logic [7:0] string_presence_bitmap,
   output logic string_enable,
   output logic ee_write_protect,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [7:0] device_id
);

   // logical index of physical port p: usable ports below it
   function automatic logic [1:0] logical_index(input logic [3:0] m,
                                                input int p);
      logic [1:0] n;
      n = 2'b00;
      for (int i = 0; i < 4; i++) begin
         if (i < p && m[i]) begin
            n = n + 2'b01;
         end
      end
      return n;
   endfunction

   load_state_t state;
   img_fmt_t fmt;
   logic [7:0] img [IMG_DEPTH];
   logic [4:0] idx;
   logic [4:0] last;
   logic [7:0] tag;
   logic sp_meta;
   logic sp_sync;
   cfg_t cfg;
   cfg_t next_cfg;
   logic ap_write;
   logic [7:0] ap_addr;
   logic [7:0] desc_req;

   // loader: byte 0 first, then the body its tag calls for
   assign ee_req = (state != S_DONE);
   assign ee_addr = {3'b000, idx};
   wire tag_ack = (state == S_TAG) && ee_ack;
   wire body_ack = (state == S_BODY) && ee_ack;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= S_TAG;
         fmt <= FMT_NONE;
         idx <= 5'h00;
         last <= 5'h00;
         tag <= 8'h00;
         vendor_class_mode <= 1'b0;
      end else begin
         unique case (state)
            S_TAG: begin
               if (ee_ack) begin
                  tag <= ee_data;
                  idx <= OFF_VID_LO;
                  state <= S_BODY;
                  unique case (ee_data)
                     TAG_SHORT: begin
                        fmt <= FMT_SHORT;
                        last <= OFF_S_FLAGS;
                     end
                     TAG_EXT: begin
                        fmt <= FMT_EXT;
                        last <= OFF_X_DET;
                     end
                     TAG_ID_ONLY: begin
                        fmt <= FMT_ID;
                        last <= OFF_DID;
                     end
                     TAG_BLANK: begin
                        vendor_class_mode <= 1'b1;
                        state <= S_DONE;
                     end
                     default: begin
                        state <= S_DONE;
                     end
                  endcase
               end
            end
            S_BODY: begin
               if (ee_ack) begin
                  if (idx == last) begin
                     state <= S_DONE;
                  end else begin
                     idx <= idx + 5'h01;
                  end
               end
            end
            // no reload: a new image only counts after the next hresetn reset
            S_DONE: begin
               state <= S_DONE;
            end
            default: begin
               state <= S_DONE;
            end
         endcase
      end
   end

   // image store; contents are read only once the format is known
   always_ff @(posedge hclk) begin
      if (tag_ack || body_ack) begin
         img[idx] <= ee_data;
      end
   end

   // strap style pin, synchronised before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_meta <= 1'b0;
         sp_sync <= 1'b0;
      end else begin
         sp_meta <= self_power_pin;
         sp_sync <= sp_meta;
      end
   end

   wire is_short = (fmt == FMT_SHORT);
   wire is_ext = (fmt == FMT_EXT);
   wire is_full = is_short || is_ext;
   wire has_ids = (fmt != FMT_NONE);
   wire [7:0] img_oc = img[OFF_OC];
   wire [7:0] img_settle_x = img[OFF_X_SETTLE];
   wire [7:0] img_budget_hs = img[OFF_X_BUDGET_HS];

   wire [7:0] oc_byte = is_full ? img_oc : DEF_OC;
   wire [7:0] ports_byte = is_short ? img[OFF_S_PORTS] :
      is_ext ? {img[OFF_X_USE][3:0], img[OFF_X_DET][3:0]} :
      DEF_PORTS;
   wire [7:0] flags_byte = is_short ? img[OFF_S_FLAGS] :
      is_ext ? img[OFF_X_FLAGS] : DEF_FLAGS;
   wire [7:0] pol_byte = is_ext ? img[OFF_X_POL] : DEF_POL;
   wire eff_hs = hs_link && !flags_byte[FLG_FS_ONLY];
   wire self_eff = sp_sync && pol_byte[POL_SELF];
   // byte 12 + {self, hs}: FS bus, HS bus, FS self, HS self
   wire [4:0] ctrl_idx = OFF_X_CTRL + {3'b000, self_eff, eff_hs};

   wire [7:0] budget = is_short ? img[OFF_S_BUDGET] :
      is_ext ? (eff_hs ? img_budget_hs : img[OFF_X_BUDGET_FS]) :
      (eff_hs ? DEF_BUDGET_HS : DEF_BUDGET_FS);
   wire [7:0] ctrl = is_short ? img[OFF_S_CTRL] :
      is_ext ? img[ctrl_idx] : (eff_hs ? DEF_CTRL_HS : DEF_CTRL_FS);
   wire [7:0] settle = is_short ? img[OFF_S_SETTLE] :
      is_ext ? img_settle_x : DEF_SETTLE;

   wire [3:0] usable = ports_byte[7:4];
   wire [3:0] detach = ports_byte[3:0];
   wire [2:0] count = 3'($countones(usable));
   wire [3:0] cnt_mask = 4'((5'h01 << count) - 5'h01);
   wire [3:0] phys_rem;
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_port
         assign phys_rem[gp] = usable[gp] &&
            detach[logical_index(usable, gp)];
      end
   endgenerate
   // descriptor bit n set means logical port n is fixed
   wire [7:0] rem_field = {3'b000, ~detach & cnt_mask, 1'b0};

   wire gang = flags_byte[FLG_GANG];
   wire oc_off = is_ext && pol_byte[POL_OC_OFF];
   wire oc_pp = is_ext ? (pol_byte[POL_OC_PP] && !oc_off) : !gang;
   wire [7:0] hubchar = {!flags_byte[FLG_NO_IND], 2'b00,
      oc_off, oc_pp, flags_byte[FLG_COMPOUND],
      1'b0, !gang};

   wire [7:0] lang = is_ext ? img[OFF_X_LANG] : 8'h00;

   always_comb begin
      next_cfg.oc = oc_byte;
      next_cfg.usable = usable;
      next_cfg.detach = detach;
      next_cfg.count = count;
      next_cfg.phys_rem = phys_rem;
      next_cfg.rem_field = rem_field;
      next_cfg.budget = budget;
      next_cfg.ctrl = ctrl;
      next_cfg.settle = settle;
      next_cfg.flags = flags_byte;
      next_cfg.pol = pol_byte;
      next_cfg.hubchar = hubchar;
      next_cfg.lang = lang;
      next_cfg.strmap = is_ext ? img[OFF_X_STR] : 8'h00;
      next_cfg.str_en = (lang != 8'h00) && (lang <= LANG_MAX);
      next_cfg.wp = is_ext && (img[OFF_X_WP] == WP_KEY);
      next_cfg.vid = has_ids ? {img[OFF_VID_HI], img[OFF_VID_LO]} : DEF_VID;
      next_cfg.pid = has_ids ? {img[OFF_PID_HI], img[OFF_PID_LO]} : DEF_PID;
      next_cfg.did = has_ids ? img[OFF_DID] : DEF_DID;
   end

   // outputs are registered every cycle, also while the load runs; config_done marks its end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= '0;
         config_done <= 1'b0;
      end else begin
         cfg <= next_cfg;
         config_done <= (state == S_DONE);
      end
   end

   assign active_port_oc_filter = cfg.oc[7:4];
   assign idle_port_oc_filter = cfg.oc[3:0];
   assign usable_port_mask = cfg.usable;
   assign detachable_port_mask = cfg.detach;
   assign port_count = cfg.count;
   assign phys_removable = cfg.phys_rem;
   assign device_removable_field = cfg.rem_field;
   assign upstream_current_budget = cfg.budget;
   assign controller_current_draw = cfg.ctrl;
   assign port_power_settle_time = cfg.settle;
   assign hub_characteristics = cfg.hubchar;
   assign accept_zero_desc_type = cfg.flags[FLG_ACCEPT0];
   assign compound_flag = cfg.flags[FLG_COMPOUND];
   assign fs_only_flag = cfg.flags[FLG_FS_ONLY];
   assign hs_enable = !cfg.flags[FLG_FS_ONLY];
   assign indicator_disable = cfg.flags[FLG_NO_IND];
   assign shared_power_switching = cfg.flags[FLG_GANG];
   assign amber_led_polarity = cfg.pol[POL_AMBER];
   assign green_led_polarity = cfg.pol[POL_GREEN];
   assign led_pulse_enable = cfg.pol[POL_PULSE];
   assign power_switch_polarity = cfg.pol[POL_PWR];
   assign oc_input_polarity = cfg.pol[POL_OC];
   assign oc_detect_disable = cfg.hubchar[4];
   assign oc_per_port_report = cfg.hubchar[3];
   assign language_count = cfg.lang;
   assign string_presence_bitmap = cfg.strmap;
   assign string_enable = cfg.str_en;
   assign ee_write_protect = cfg.wp;
   assign vendor_id = cfg.vid;
   assign product_id = cfg.pid;
   assign device_id = cfg.did;

   // descriptor type check steered by software through the bus
   wire desc_stall = (desc_req != DESC_TYPE_HUB) &&
      !((desc_req == DESC_TYPE_ZERO) && accept_zero_desc_type);

   // AHB-Lite slave, zero wait states, word access only
   wire take = hsel && hready && htrans[1] && (hsize == 3'b010);
   wire mapped = (haddr[31:8] == 24'h00_0000);
   wire [7:0] ra = haddr[7:0];
   wire [31:0] rd_word = !mapped ? 32'h0000_0000 :
      (ra == REG_STATUS) ? {16'h0000, tag, 3'b000, desc_stall, is_ext,
         is_short, vendor_class_mode, config_done} :
      (ra == REG_DESC_REQ) ? {24'h00_0000, desc_req} :
      (ra == REG_OC) ? {24'h00_0000, cfg.oc} :
      (ra == REG_PORTS) ? {16'h0000, cfg.phys_rem, 1'b0, cfg.count,
         cfg.detach, cfg.usable} :
      (ra == REG_POWER) ? {8'h00, cfg.settle, cfg.ctrl, cfg.budget} :
      (ra == REG_HUBCHAR) ? {16'h0000, cfg.flags, cfg.hubchar} :
      (ra == REG_POLARITY) ? {24'h00_0000, cfg.pol} :
      (ra == REG_STRINGS) ? {14'h0000, cfg.wp, cfg.str_en, cfg.strmap,
         cfg.lang} :
      (ra == REG_IDS) ? {cfg.pid, cfg.vid} :
      (ra == REG_DID) ? {24'h00_0000, cfg.did} : 32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         desc_req <= DESC_TYPE_HUB;
      end else begin
         ap_write <= take && hwrite && mapped;
         ap_addr <= ra;
         if (take && !hwrite) begin
            hrdata <= rd_word;
         end
         if (ap_write && (ap_addr == REG_DESC_REQ)) begin
            desc_req <= hwdata[7:0];
         end
      end
   end

   // checks
   wire loaded = config_done && is_full;
   sequence s_tag_seen(logic [7:0] t);
      tag_ack && (ee_data == t);
   endsequence

   chk_tag_first_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (state == S_TAG) |-> (ee_req && ee_addr == 8'h00))
      else $error("first read is not byte 0");

   chk_blank_vendor: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_tag_seen(TAG_BLANK) |=> ##1 (vendor_class_mode && config_done))
      else $error("blank image did not select vendor class");

   chk_oc_filter_split: assert property (
      @(posedge hclk) disable iff (!hresetn)
      loaded |=> (active_port_oc_filter == $past(img_oc[7:4]) &&
         idle_port_oc_filter == $past(img_oc[3:0])))
      else $error("filter nibbles do not follow byte 7");

   chk_oc_default: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (config_done && !is_full) |=> (cfg.oc == DEF_OC))
      else $error("default filter time is not 8 ms");

   chk_port_count: assert property (
      @(posedge hclk) disable iff (!hresetn)
      config_done |-> (port_count == $countones(usable_port_mask)))
      else $error("port count differs from usable mask");

   chk_desc_zero_stall: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (desc_req == DESC_TYPE_ZERO) |-> (desc_stall != accept_zero_desc_type))
      else $error("type zero stall does not follow flag");

   chk_budget_speed: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (config_done && is_ext && eff_hs) ##1 $stable(eff_hs)
      |-> (upstream_current_budget == $past(img_budget_hs)))
      else $error("high speed budget not taken from byte 9");

   chk_settle_ext: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (config_done && is_ext) |=> (port_power_settle_time ==
         $past(img_settle_x)))
      else $error("settle time not taken from byte 16");

   chk_gang_bits: assert property (
      @(posedge hclk) disable iff (!hresetn)
      config_done |-> (hub_characteristics[1:0] ==
         (shared_power_switching ? 2'b00 : 2'b01)))
      else $error("power switching bits disagree with flag");

   chk_indicator_bit: assert property (
      @(posedge hclk) disable iff (!hresetn)
      config_done |-> (hub_characteristics[7] == !indicator_disable))
      else $error("indicator bit disagrees with flag");

endmodule

// ==== tb/ee_image_model.sv ====
/*
 ee_image_model: serial EEPROM byte reader stand-in serving a 24-byte
 image, answering after 0 to 3 idle cycles as lag asks.
 Assumes the loader holds ee_req and ee_addr until it sees ee_ack.
*/
`timescale 1ns/1ps
module ee_image_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic [7:0] img [24],
   input wire logic [1:0] lag,
   output logic ee_ack,
   output logic [7:0] ee_data
);
   logic [1:0] cnt;
   initial begin
      ee_ack = 1'b0;
      ee_data = 8'h00;
      cnt = 2'h0;
   end
   // data toggles between acks so a sample one cycle late never sees a stale byte
   always @(posedge hclk) begin
      if (!hresetn || ee_ack || !ee_req || cnt != lag) begin
         ee_ack <= 1'b0;
         ee_data <= ~ee_data;
         cnt <= (hresetn && ee_req && !ee_ack) ? cnt + 2'h1 : 2'h0;
      end else begin
         ee_ack <= 1'b1;
         ee_data <= img[ee_addr[4:0]];
         cnt <= 2'h0;
      end
   end
endmodule

// ==== tb/test_hub_eeprom_config_loader.sv ====
/*
 test_hub_eeprom_config_loader: loads random images of every format
 through the EEPROM model and compares outputs and the status register
 with a model built from the image. Assumes 0 wait-state AHB-Lite slave.
*/
`timescale 1ns/1ps
module test_hub_eeprom_config_loader;
   import hub_cfg_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ee_req;
   logic ee_ack, hs_link, self_power_pin, config_done, vendor_class_mode;
   logic hs_enable, accept_zero_desc_type, compound_flag, fs_only_flag;
   logic indicator_disable, shared_power_switching, amber_led_polarity;
   logic green_led_polarity, led_pulse_enable, power_switch_polarity;
   logic oc_input_polarity, oc_detect_disable, oc_per_port_report;
   logic string_enable, ee_write_protect;
   logic [1:0] htrans, lag;
   logic [2:0] hsize, port_count;
   logic [3:0] active_port_oc_filter, idle_port_oc_filter, phys_removable;
   logic [3:0] usable_port_mask, detachable_port_mask;
   logic [7:0] ee_addr, ee_data, device_removable_field, device_id;
   logic [7:0] upstream_current_budget, controller_current_draw;
   logic [7:0] port_power_settle_time, hub_characteristics, language_count;
   logic [7:0] string_presence_bitmap, img [24];
   logic [15:0] vendor_id, product_id;
   logic [31:0] haddr, hwdata, hrdata, seed, rd;
   int n_errors, n_checks;
   assign hready = hreadyout;
   hub_eeprom_config_loader hub_eeprom_config_loader_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .ee_req, .ee_addr, .ee_ack,
      .ee_data, .hs_link, .self_power_pin, .config_done, .vendor_class_mode,
      .hs_enable, .active_port_oc_filter, .idle_port_oc_filter,
      .usable_port_mask, .detachable_port_mask, .port_count, .phys_removable,
      .device_removable_field, .upstream_current_budget,
      .controller_current_draw, .port_power_settle_time, .hub_characteristics,
      .accept_zero_desc_type, .compound_flag, .fs_only_flag,
      .indicator_disable, .shared_power_switching, .amber_led_polarity,
      .green_led_polarity, .led_pulse_enable, .power_switch_polarity,
      .oc_input_polarity, .oc_detect_disable, .oc_per_port_report,
      .language_count, .string_presence_bitmap, .string_enable,
      .ee_write_protect, .vendor_id, .product_id, .device_id);
   ee_image_model ee_image_model_inst (.hclk, .hresetn, .ee_req, .ee_addr,
      .img, .lag, .ee_ack, .ee_data);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(logic w, logic [31:0] a, logic [31:0] wd);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      chk("hreadyout", 1'b1, hreadyout);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      chk("hreadyout", 1'b1, hreadyout);
      chk("hresp", 1'b0, hresp);
      rd = hrdata;
   endtask
   task automatic run(logic [7:0] tag, logic hs, logic sp, logic [1:0] l);
      int k, c, n;
      logic [7:0] b, f, p, rf, t;
      logic [3:0] u, d, ph;
      logic x, s, q, o;
      @(posedge hclk);
      for (k = 0; k < 24; k++) begin
         b = xs();
         // reserved flag bits written as zero
         img[k] <= k == 0 ? tag :
            (k == 12 || k == 17) ? b & 8'hf4 : b;
      end
      hs_link <= hs;
      self_power_pin <= sp;
      lag <= l;
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      n = 0;
      while (config_done !== 1'b1 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      chk("config_done", 1'b1, config_done);
      x = tag == TAG_EXT;
      s = tag == TAG_SHORT;
      f = x ? img[17] : s ? img[12] : DEF_FLAGS;
      p = x ? img[18] : 8'h00;
      q = hs & ~f[5];
      // oc disabled wins over per-port; without byte 18 it follows gang
      o = x ? p[0] & ~p[1] : ~f[2];
      u = x ? img[22][3:0] : s ? img[8][7:4] : 4'hf;
      d = x ? img[23][3:0] : s ? img[8][3:0] : 4'hf;
      c = 0;
      ph = 4'h0;
      rf = 8'h00;
      for (k = 0; k < 4; k++) if (u[k]) begin
         ph[k] = d[c];
         rf[c+1] = ~d[c];
         c++;
      end
      chk("oc", x | s ? img[7] : 8'h88,
         {active_port_oc_filter, idle_port_oc_filter});
      chk("ports", {u, d, 1'b0, c[2:0]},
         {usable_port_mask, detachable_port_mask, 1'b0, port_count});
      chk("removable", {ph, rf},
         {phys_removable, device_removable_field});
      chk("budget", x ? (q ? img[9] : img[8]) : s ? img[9] :
         q ? 8'h57 : 8'h28, upstream_current_budget);
      chk("ctrl", x ? img[12+q+2*(sp&p[5])] : s ? img[10] :
         q ? 8'hae : 8'h50, controller_current_draw);
      chk("settle", x ? img[16] : s ? img[11] : 8'h32,
         port_power_settle_time);
      chk("hubchar",
         {~f[4], 2'b0, x & p[1], o, f[6], 1'b0, ~f[2]}, hub_characteristics);
      chk("flags", {f[7], f[6], f[5], f[4], f[2], ~f[5]},
         {accept_zero_desc_type, compound_flag, fs_only_flag,
         indicator_disable, shared_power_switching, hs_enable});
      chk("pol", {p[7], p[6], p[4], p[3], p[2], p[1], o},
         {amber_led_polarity, green_led_polarity, led_pulse_enable,
         power_switch_polarity, oc_input_polarity, oc_detect_disable,
         oc_per_port_report});
      chk("strings", {x ? {img[20], img[21]} : 16'h0000,
         x && img[20] != 8'h00 && img[20] <= LANG_MAX,
         x && img[19] == WP_KEY}, {language_count, string_presence_bitmap,
         string_enable, ee_write_protect});
      t = x | s | tag == TAG_ID_ONLY ? 8'hff : 8'h00;
      chk("ids", {img[4], img[3], img[2], img[1]} & {4{t}},
         {product_id, vendor_id});
      chk("did", img[6] & t, device_id);
      chk("vendor", tag == TAG_BLANK, vendor_class_mode);
      ahb(1'b0, 32'(REG_STATUS), 32'h0);
      chk("status", {tag, 4'h0, x, s, tag == TAG_BLANK, 1'b1}, rd);
      for (k = 0; k < 3; k++) begin
         t = k == 0 ? 8'h00 : k == 1 ? 8'h29 : 8'h3c;
         ahb(1'b1, 32'(REG_DESC_REQ), {24'h0, t});
         ahb(1'b0, 32'(REG_STATUS), 32'h0);
         chk("stall", t != 8'h29 && !(t == 8'h00 && f[7]), rd[4]);
      end
      ahb(1'b0, 32'h0000_0100, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test with image tag %h done", tag);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] tags [12];
      seed = 32'hbd5b;
      {hresetn, hsel, hwrite, hs_link, self_power_pin} = 5'h0;
      {htrans, lag, haddr, hwdata} = '0;
      hsize = 3'b010;
      foreach (img[k]) img[k] = 8'hff;
      tags = '{8'hff, 8'hd0, 8'hd2, 8'hd4, 8'h5a, 8'hd2, 8'hd4, 8'hd2,
         8'hd4, 8'hd2, 8'hd4, 8'hd4};
      foreach (tags[k]) begin
         seed = xs();
         run(tags[k], seed[3], seed[9], 2'(k));
      end
      tally_and_finish();
   end
endmodule
